// file: design/ipw_pkg.sv
// ==========================================================================
// Shared constants of the indexed port watchdog
package ipw_pkg;

  // ========================================================================
  // I/O port addresses
  localparam logic [15:0] IDX_PORT     = 16'h002E;  // Index (address) port
  localparam logic [15:0] DAT_PORT     = 16'h002F;  // Data port

  // ========================================================================
  // Key values written to the index port
  localparam logic [7:0]  KEY_UNLOCK   = 8'h87;     // Written twice to open
  localparam logic [7:0]  KEY_LOCK     = 8'hAA;     // Closes the space

  // ========================================================================
  // Register indices
  localparam logic [7:0]  REG_BANK     = 8'h07;     // Function bank select
  localparam logic [7:0]  REG_ENABLE   = 8'h30;     // Watchdog enable
  localparam logic [7:0]  REG_UNIT     = 8'hF5;     // Unit configuration
  localparam logic [7:0]  REG_COUNT    = 8'hF6;     // Count value
  localparam logic [7:0]  REG_CTRL     = 8'hF7;     // Control and status

  // ========================================================================
  // Field values and positions
  localparam logic [7:0]  BANK_WDT     = 8'h08;     // Watchdog bank code
  localparam logic [7:0]  ENABLE_ON    = 8'h01;     // Enable value
  localparam int          UNIT_MIN_BIT = 3;         // Minutes when set
  localparam int          FAST_BIT     = 4;         // Thousand times faster
  localparam int          KBD_EN_BIT   = 6;         // Keyboard restarts count
  localparam int          FORCE_BIT    = 5;         // Force timeout, self clear
  localparam int          STATUS_BIT   = 4;         // Timed out

  // ========================================================================
  // Values after reset
  localparam logic [7:0]  BANK_RST     = 8'h00;
  localparam logic [7:0]  ENABLE_RST   = 8'h00;
  localparam logic [7:0]  COUNT_RST    = 8'h00;
  localparam logic [7:0]  INDEX_RST    = 8'h00;
  localparam logic [7:0]  RDATA_IDLE   = 8'hFF;     // Read of a closed space

  // ========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_TIME_NS    = 1000000;
  localparam int unsigned MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_SEC    = 1000;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int unsigned MS_PER_FMIN   = 60;       // 1/1000 minute = 60 ms

  // ========================================================================
  // Configuration key states
  typedef enum logic [1:0] {
    ST_LOCKED = 2'b00,
    ST_HALF   = 2'b01,
    ST_OPEN   = 2'b10
  } ipw_key_t;

endpackage : ipw_pkg

// file: design/ipw_prescaler.sv
`timescale 1ns/1ns
// ==========================================================================
// Tick prescaler: ms, 60 ms, second and minute pulses
module ipw_prescaler #(
  parameter int unsigned MS_CYCLES   = ipw_pkg::MS_CYCLES,
  parameter int unsigned MS_PER_SEC  = ipw_pkg::MS_PER_SEC,
  parameter int unsigned SEC_PER_MIN = ipw_pkg::SEC_PER_MIN,
  parameter int unsigned MS_PER_FMIN = ipw_pkg::MS_PER_FMIN
) (
  // Clock and control
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic ce_i,
  input  wire logic restart_i,
  // Tick pulses
  output logic      ms_tick_o,
  output logic      fmin_tick_o,
  output logic      sec_tick_o,
  output logic      min_tick_o
);

  localparam int MSW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam int SCW = $clog2(MS_PER_SEC);
  localparam int MNW = $clog2(SEC_PER_MIN);
  localparam int FMW = $clog2(MS_PER_FMIN);

  // ========================================================================
  // State
  typedef struct packed {
    logic [MSW-1:0] ms_cnt;     // Cycles within a millisecond
    logic [SCW-1:0] sec_ms;     // Milliseconds within a second
    logic [FMW-1:0] fmin_ms;    // Milliseconds within a fast minute
    logic [MNW-1:0] min_sec;    // Seconds within a minute
    logic           ms_tick;
    logic           fmin_tick;
    logic           sec_tick;
    logic           min_tick;
  } ipw_pre_t;

  ipw_pre_t q;
  ipw_pre_t next_q;

  // ========================================================================
  // Chained counters; a restart realigns every phase to zero
  always_comb begin
    next_q           = q;
    next_q.ms_tick   = 1'b0;
    next_q.fmin_tick = 1'b0;
    next_q.sec_tick  = 1'b0;
    next_q.min_tick  = 1'b0;
    if (restart_i) begin
      // Full unit from the reload, never a partial first period
      next_q.ms_cnt  = '0;
      next_q.sec_ms  = '0;
      next_q.fmin_ms = '0;
      next_q.min_sec = '0;
    end else if (q.ms_cnt == MSW'(MS_CYCLES - 1)) begin  // see [RL15]
      next_q.ms_cnt  = '0;
      next_q.ms_tick = 1'b1;
      // Fast minute
      if (q.fmin_ms == FMW'(MS_PER_FMIN - 1)) begin
        next_q.fmin_ms   = '0;
        next_q.fmin_tick = 1'b1;
      end else begin
        next_q.fmin_ms = q.fmin_ms + FMW'(1);
      end
      // Second, and minute on top of it
      if (q.sec_ms == SCW'(MS_PER_SEC - 1)) begin
        next_q.sec_ms   = '0;
        next_q.sec_tick = 1'b1;
        if (q.min_sec == MNW'(SEC_PER_MIN - 1)) begin
          next_q.min_sec  = '0;
          next_q.min_tick = 1'b1;
        end else begin
          next_q.min_sec = q.min_sec + MNW'(1);
        end
      end else begin
        next_q.sec_ms = q.sec_ms + SCW'(1);
      end
    end else begin
      next_q.ms_cnt = q.ms_cnt + MSW'(1);
    end
  end

  // ========================================================================
  // Register; clock enable freezes everything
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      q <= '0;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign ms_tick_o   = q.ms_tick;
  assign fmin_tick_o = q.fmin_tick;
  assign sec_tick_o  = q.sec_tick;
  assign min_tick_o  = q.min_tick;

endmodule : ipw_prescaler

// file: design/ipw_watchdog.sv
`timescale 1ns/1ns
// ==========================================================================
// Watchdog timer behind an index/data I/O port pair
//
// Notes on behaviour
// [RL1] Registers reached by index port, then data port
// [RL2] Unlock key twice in a row opens space
// [RL3] Lock key closes space to data accesses
// [RL4] Watchdog bank code routes accesses to watchdog
// [RL5] Runs only when enabled; disabled after reset
// [RL6] Unit bit: clear seconds, set minutes
// [RL7] Fast bit shrinks unit by one thousand
// [RL8] Zero count stops timer; resets to zero
// [RL9] Nonzero count: units before timeout asserts
// [RL10] Count write reloads and restarts timer
// [RL11] Keyboard strobe restarts count when enabled
// [RL12] Force bit asserts timeout, reads back zero; code forces only while enable holds ENABLE_ON
// [RL13] Status bit reads one after expiry
// [RL14] Software must restart before period expires
// [RL15] Prescaler ticks from clock; one decrement each
module ipw_watchdog #(
  parameter int unsigned MS_CYCLES = ipw_pkg::MS_CYCLES  // Cycles per millisecond
) (
  // Clock, reset, enable
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  // Host I/O cycles
  input  wire logic [15:0] IO_ADDR_I,
  input  wire logic        IO_WR_I,
  input  wire logic        IO_RD_I,
  input  wire logic [7:0]  IO_WDATA_I,
  output logic      [7:0]  IO_RDATA_O,
  // Keyboard activity
  input  wire logic        KBD_STROBE_I,
  // Watchdog results
  output logic             WDT_TIMEOUT_O,
  output logic             WDT_COUNTING_O
);

  // ========================================================================
  // State
  typedef struct packed {
    ipw_pkg::ipw_key_t key;        // Configuration lock state
    logic [7:0]        index;      // Selected register
    logic [7:0]        bank;       // Function bank
    logic [7:0]        enable;     // Enable register
    logic              unit_min;   // Minutes unit
    logic              fast;       // Thousand times faster
    logic [7:0]        count;      // Programmed count
    logic [7:0]        remaining;  // Units left
    logic              kbd_en;     // Keyboard restarts count
    logic              expired;    // Timed out
    logic [7:0]        rdata;      // Read data
  } ipw_state_t;

  localparam ipw_state_t STATE_RST = '{
    key:       ipw_pkg::ST_LOCKED,
    index:     ipw_pkg::INDEX_RST,
    bank:      ipw_pkg::BANK_RST,
    enable:    ipw_pkg::ENABLE_RST,
    unit_min:  1'b0,
    fast:      1'b0,
    count:     ipw_pkg::COUNT_RST,
    remaining: ipw_pkg::COUNT_RST,
    kbd_en:    1'b0,
    expired:   1'b0,
    rdata:     ipw_pkg::RDATA_IDLE
  };

  ipw_state_t q;
  ipw_state_t next_q;

  // Prescaler handshake
  logic restart;     // Realign prescaler phase
  logic ms_tick;     // Fast seconds unit
  logic fmin_tick;   // Fast minutes unit
  logic sec_tick;    // Seconds unit
  logic min_tick;    // Minutes unit

  // ========================================================================
  // Tick source
  ipw_prescaler #(
    .MS_CYCLES   (MS_CYCLES),
    .MS_PER_SEC  (ipw_pkg::MS_PER_SEC),
    .SEC_PER_MIN (ipw_pkg::SEC_PER_MIN),
    .MS_PER_FMIN (ipw_pkg::MS_PER_FMIN)
  ) u_prescaler (
    .CLK_I       (CLK_I),
    .RST_I       (RST_I),
    .ce_i        (CE_I),
    .restart_i   (restart),
    .ms_tick_o   (ms_tick),
    .fmin_tick_o (fmin_tick),
    .sec_tick_o  (sec_tick),
    .min_tick_o  (min_tick)
  );

  // ========================================================================
  // Read multiplexer for the data port
  function automatic logic [7:0] read_reg(input ipw_state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (s.index == ipw_pkg::REG_BANK) begin
      v = s.bank;
    end else if (s.bank == ipw_pkg::BANK_WDT) begin  // see [RL4]
      case (s.index)
        ipw_pkg::REG_ENABLE: v = s.enable;
        ipw_pkg::REG_UNIT: begin
          v[ipw_pkg::UNIT_MIN_BIT] = s.unit_min;
          v[ipw_pkg::FAST_BIT]     = s.fast;
        end
        ipw_pkg::REG_COUNT: v = s.count;
        ipw_pkg::REG_CTRL: begin
          v[ipw_pkg::KBD_EN_BIT] = s.kbd_en;
          // Force bit always reads zero
          v[ipw_pkg::STATUS_BIT] = s.expired;  // see [RL13]
        end
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction : read_reg

  // ========================================================================
  // Port decode, key sequence, registers and countdown
  always_comb begin
    logic idx_wr;       // Write to index port
    logic dat_wr;       // Write to data port
    logic idx_rd;       // Read of index port
    logic dat_rd;       // Read of data port
    logic is_open;      // Configuration space open
    logic wdt_sel;      // Watchdog bank selected
    logic reload;       // Count write
    logic kbd_reload;   // Keyboard restart
    logic force_to;     // Forced timeout
    logic tick;         // Selected unit tick
    logic running;      // Countdown may advance
    idx_wr     = 1'b0;
    dat_wr     = 1'b0;
    idx_rd     = 1'b0;
    dat_rd     = 1'b0;
    is_open    = 1'b0;
    wdt_sel    = 1'b0;
    reload     = 1'b0;
    kbd_reload = 1'b0;
    force_to   = 1'b0;
    tick       = 1'b0;
    running    = 1'b0;
    next_q     = q;

    idx_wr  = IO_WR_I && (IO_ADDR_I == ipw_pkg::IDX_PORT);  // see [RL1]
    dat_wr  = IO_WR_I && (IO_ADDR_I == ipw_pkg::DAT_PORT);
    idx_rd  = IO_RD_I && (IO_ADDR_I == ipw_pkg::IDX_PORT);
    dat_rd  = IO_RD_I && (IO_ADDR_I == ipw_pkg::DAT_PORT);
    is_open = (q.key == ipw_pkg::ST_OPEN);
    wdt_sel = (q.bank == ipw_pkg::BANK_WDT);

    // Key sequence on index port writes
    if (idx_wr) begin
      case (q.key)
        ipw_pkg::ST_LOCKED: begin
          if (IO_WDATA_I == ipw_pkg::KEY_UNLOCK) begin
            next_q.key = ipw_pkg::ST_HALF;
          end
        end
        ipw_pkg::ST_HALF: begin
          // Any other value breaks the pair
          if (IO_WDATA_I == ipw_pkg::KEY_UNLOCK) begin
            next_q.key = ipw_pkg::ST_OPEN;  // see [RL2]
          end else begin
            next_q.key = ipw_pkg::ST_LOCKED;
          end
        end
        ipw_pkg::ST_OPEN: begin
          if (IO_WDATA_I == ipw_pkg::KEY_LOCK) begin
            next_q.key = ipw_pkg::ST_LOCKED;  // see [RL3]
          end else begin
            next_q.index = IO_WDATA_I;  // see [RL1]
          end
        end
        default: next_q.key = ipw_pkg::ST_LOCKED;
      endcase
    end

    // Data port writes reach registers only while open
    if (dat_wr && is_open) begin  // see [RL3]
      if (q.index == ipw_pkg::REG_BANK) begin
        next_q.bank = IO_WDATA_I;  // see [RL4]
      end else if (wdt_sel) begin  // see [RL4]
        case (q.index)
          ipw_pkg::REG_ENABLE: next_q.enable = IO_WDATA_I;
          ipw_pkg::REG_UNIT: begin
            next_q.unit_min = IO_WDATA_I[ipw_pkg::UNIT_MIN_BIT];  // see [RL6]
            next_q.fast     = IO_WDATA_I[ipw_pkg::FAST_BIT];      // see [RL7]
          end
          ipw_pkg::REG_COUNT: begin
            next_q.count     = IO_WDATA_I;
            next_q.remaining = IO_WDATA_I;  // see [RL10]
            reload           = 1'b1;
          end
          ipw_pkg::REG_CTRL: begin
            next_q.kbd_en = IO_WDATA_I[ipw_pkg::KBD_EN_BIT];  // see [RL11]
            force_to      = IO_WDATA_I[ipw_pkg::FORCE_BIT];   // see [RL12]
          end
          default: next_q.enable = q.enable;  // Unmapped index ignored
        endcase
      end
    end

    // Keyboard activity restarts from the programmed count
    if (KBD_STROBE_I && q.kbd_en && !reload) begin
      next_q.remaining = q.count;  // see [RL11]
      kbd_reload       = 1'b1;
    end
    restart = reload || kbd_reload;

    // A restart clears the old timeout before any new set below
    if (restart) begin
      next_q.expired = 1'b0;
    end

    // Unit selection
    case ({q.unit_min, q.fast})
      2'b00:   tick = sec_tick;   // see [RL6]
      2'b10:   tick = min_tick;   // see [RL6]
      2'b01:   tick = ms_tick;    // see [RL7]
      2'b11:   tick = fmin_tick;  // see [RL7]
      default: tick = 1'b0;
    endcase

    // Zero count holds the timer stopped; a restart keeps its reload value
    running = (q.enable == ipw_pkg::ENABLE_ON)   // see [RL5]
              && (q.remaining != 8'h00);         // see [RL8]
    if (running && tick) begin
      if (!restart) begin
        next_q.remaining = q.remaining - 8'h01;  // see [RL15]
      end
      // Expiry in a restart cycle still sets the flag: set wins
      if (q.remaining == 8'h01) begin
        next_q.expired = 1'b1;  // see [RL9]
      end
    end

    // Forced timeout needs the function enabled; set wins over restart
    if (force_to && (q.enable == ipw_pkg::ENABLE_ON)) begin
      next_q.expired = 1'b1;  // see [RL12]
    end

    // Registered read data
    if (dat_rd) begin
      next_q.rdata = is_open ? read_reg(q) : ipw_pkg::RDATA_IDLE;
    end else if (idx_rd) begin
      next_q.rdata = is_open ? q.index : ipw_pkg::RDATA_IDLE;
    end
  end

  // ========================================================================
  // State register; clock enable freezes all state
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      q <= STATE_RST;  // see [RL5] [RL8] [RL11]
    end else if (CE_I) begin
      q <= next_q;
    end
  end

  // ========================================================================
  // Outputs
  assign IO_RDATA_O     = q.rdata;
  assign WDT_TIMEOUT_O  = q.expired;
  assign WDT_COUNTING_O = (q.enable == ipw_pkg::ENABLE_ON) && (q.remaining != 8'h00);

endmodule : ipw_watchdog

// file: testbench/ipw_watchdog_props.sv
`timescale 1ns/1ns
// ==========================================================================
// Port-level checker of the indexed port watchdog
module ipw_watchdog_props #(
  parameter int unsigned MS_CYCLES = ipw_pkg::MS_CYCLES  // Cycles per millisecond
) (
  // Clock, reset, enable
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        CE_I,
  // Host I/O cycles
  input wire logic [15:0] IO_ADDR_I,
  input wire logic        IO_WR_I,
  input wire logic        IO_RD_I,
  input wire logic [7:0]  IO_WDATA_I,
  input wire logic [7:0]  IO_RDATA_O,
  // Keyboard and results
  input wire logic        KBD_STROBE_I,
  input wire logic        WDT_TIMEOUT_O,
  input wire logic        WDT_COUNTING_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ========================================================================
  // Helper logic
  logic [7:0]  idx;  // Last index byte seen; lock state not tracked
  logic [15:0] gap;  // Cycles since a count write, saturating
  logic        cwr;  // Count register write
  logic        fwr;  // Control write with the force bit
  assign cwr = IO_WR_I && CE_I && IO_ADDR_I == ipw_pkg::DAT_PORT && idx == ipw_pkg::REG_COUNT;
  assign fwr = IO_WR_I && CE_I && IO_ADDR_I == ipw_pkg::DAT_PORT && idx == ipw_pkg::REG_CTRL
               && IO_WDATA_I[ipw_pkg::FORCE_BIT];
  // Index and gap tracking
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      idx <= ipw_pkg::INDEX_RST;
      gap <= 16'h0000;
    end else begin
      if (IO_WR_I && CE_I && IO_ADDR_I == ipw_pkg::IDX_PORT) idx <= IO_WDATA_I;
      gap <= cwr ? 16'h0000 : (gap == 16'hFFFF ? gap : gap + 16'h0001);
    end
  end
  // ========================================================================
  // Assertions
  chk_reset_quiet: assert property ($fell(RST_I) |-> !WDT_TIMEOUT_O && !WDT_COUNTING_O
    && IO_RDATA_O == ipw_pkg::RDATA_IDLE) else $error("outputs not idle after reset");
  chk_rdata_hold: assert property (!IO_RD_I |=> $stable(IO_RDATA_O))
    else $error("read data moved without a read");
  chk_timeout_hold: assert property (WDT_TIMEOUT_O && !IO_WR_I && !KBD_STROBE_I
    |=> WDT_TIMEOUT_O) else $error("timeout dropped without restart");
  chk_idle_quiet: assert property (!WDT_COUNTING_O && !IO_WR_I
    |=> !$rose(WDT_TIMEOUT_O)) else $error("stopped timer timed out");
  chk_count_keeps: assert property (WDT_COUNTING_O && !IO_WR_I
    |=> WDT_COUNTING_O || WDT_TIMEOUT_O) else $error("count stopped without timeout");
  chk_tick_spacing: assert property ($rose(WDT_TIMEOUT_O) && !$past(fwr)
    |-> gap >= MS_CYCLES) else $error("expiry sooner than one unit");
  chk_force_now: assert property (fwr && WDT_COUNTING_O |=> WDT_TIMEOUT_O)
    else $error("force did not time out");
  // Stopped timer only: a running one may expire in the reload cycle
  chk_reload_clears: assert property (cwr && !WDT_COUNTING_O |=> !WDT_TIMEOUT_O)
    else $error("count write left timeout set");
  // Main scenarios reached
  cov_expiry: cover property ($rose(WDT_TIMEOUT_O));
  cov_kbd: cover property (KBD_STROBE_I && WDT_COUNTING_O);
  cov_force: cover property (fwr && WDT_COUNTING_O);
endmodule : ipw_watchdog_props

bind ipw_watchdog ipw_watchdog_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .IO_ADDR_I(IO_ADDR_I), .IO_WR_I(IO_WR_I),
  .IO_RD_I(IO_RD_I), .IO_WDATA_I(IO_WDATA_I), .IO_RDATA_O(IO_RDATA_O),
  .KBD_STROBE_I(KBD_STROBE_I), .WDT_TIMEOUT_O(WDT_TIMEOUT_O), .WDT_COUNTING_O(WDT_COUNTING_O));

// file: testbench/ipw_host_model.sv
`timescale 1ns/1ns
// ==========================================================================
// Host side: byte I/O cycles on the index and data ports
module ipw_host_model (
  // Clock and read data
  input  wire logic        clk_i,
  input  wire logic [7:0]  io_rdata_i,
  // I/O cycle outputs
  output logic      [15:0] io_addr_o,
  output logic             io_wr_o,
  output logic             io_rd_o,
  output logic      [7:0]  io_wdata_o
);
  // Idle bus at time zero
  initial begin
    io_addr_o  = 16'h0000;
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_wdata_o = 8'h00;
  end
  // One strobe cycle; bus inverted after release so stale values never match
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    @(negedge clk_i);
    io_addr_o  = a;
    io_wr_o    = w;
    io_rd_o    = !w;
    io_wdata_o = d;
    @(negedge clk_i);
    q          = io_rdata_i;
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_addr_o  = ~a;
    io_wdata_o = ~d;
  endtask : io
  // Index first, then data
  task automatic put(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    io(ipw_pkg::IDX_PORT, 1'b1, i, q);
    io(ipw_pkg::DAT_PORT, 1'b1, d, q);
  endtask : put
  task automatic get(input logic [7:0] i, output logic [7:0] q);
    io(ipw_pkg::IDX_PORT, 1'b1, i, q);
    io(ipw_pkg::DAT_PORT, 1'b0, 8'h00, q);
  endtask : get
  // Key pair, then watchdog bank
  task automatic open_space();
    logic [7:0] q;
    io(ipw_pkg::IDX_PORT, 1'b1, ipw_pkg::KEY_UNLOCK, q);
    io(ipw_pkg::IDX_PORT, 1'b1, ipw_pkg::KEY_UNLOCK, q);
    put(ipw_pkg::REG_BANK, ipw_pkg::BANK_WDT);
  endtask : open_space
  task automatic close_space();
    logic [7:0] q;
    io(ipw_pkg::IDX_PORT, 1'b1, ipw_pkg::KEY_LOCK, q);
  endtask : close_space
endmodule : ipw_host_model

// file: testbench/ipw_watchdog_tb_top.sv
`timescale 1ns/1ns
// ==========================================================================
// Self-checking bench of the indexed port watchdog
module ipw_watchdog_tb_top;
  localparam int MSC = 10;  // Short millisecond keeps the run brief
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        kbd = 1'b0;
  logic        ce = 1'b1;  // Clock enable, dropped once to freeze the count
  logic [15:0] addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        tmo;
  logic        cnt;
  int          n_fail = 0;
  int          tests_run = 0;
  always #5 clk = ~clk;
  // ========================================================================
  // Host model and design
  ipw_host_model u_host (.clk_i(clk), .io_rdata_i(rdata), .io_addr_o(addr), .io_wr_o(wr),
                         .io_rd_o(rd), .io_wdata_o(wdata));
  ipw_watchdog #(.MS_CYCLES(MSC)) u_dut (.CLK_I(clk), .RST_I(rst), .CE_I(ce),
    .IO_ADDR_I(addr), .IO_WR_I(wr), .IO_RD_I(rd), .IO_WDATA_I(wdata), .IO_RDATA_O(rdata),
    .KBD_STROBE_I(kbd), .WDT_TIMEOUT_O(tmo), .WDT_COUNTING_O(cnt));
  // ========================================================================
  // Compares and helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk_win(input int n, input int e);
    tests_run++;
    if (n < e - 1 || n > e + 3) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, n, e);
    end
  endtask : chk_win
  // Cycles until the timeout rises, bounded
  task automatic measure(input int e, output int n);
    n = 0;
    while (tmo !== 1'b1 && n < e + 50) begin
      @(negedge clk);
      n++;
    end
  endtask : measure
  // ========================================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] q;
    chk8({tmo, cnt}, 8'h00);
    u_host.get(ipw_pkg::REG_COUNT, q);
    chk8(q, ipw_pkg::RDATA_IDLE);
    u_host.open_space();
    u_host.get(ipw_pkg::REG_COUNT, q);
    chk8(q, ipw_pkg::COUNT_RST);
    u_host.get(ipw_pkg::REG_CTRL, q);
    chk8(q, 8'h00);
    u_host.get(ipw_pkg::REG_UNIT, q);
    chk8(q, 8'h00);
    u_host.put(ipw_pkg::REG_UNIT, 8'h10);         // Fast unit: 2 counts expire in 20 cycles
    u_host.put(ipw_pkg::REG_COUNT, 8'h02);        // Still disabled
    repeat (40) @(negedge clk);
    chk8({tmo, cnt}, 8'h00);
    u_host.put(ipw_pkg::REG_COUNT, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_lock();
    logic [7:0] q;
    u_host.put(ipw_pkg::REG_ENABLE, ipw_pkg::ENABLE_ON);
    u_host.close_space();
    u_host.put(ipw_pkg::REG_COUNT, 8'h05);                // Must be ignored
    chk8(cnt, 8'h00);
    u_host.get(ipw_pkg::REG_COUNT, q);
    chk8(q, ipw_pkg::RDATA_IDLE);
    u_host.open_space();
    u_host.get(ipw_pkg::REG_COUNT, q);
    chk8(q, 8'h00);
    u_host.io(ipw_pkg::IDX_PORT, 1'b0, 8'h00, q);         // Index port read
    chk8(q, ipw_pkg::REG_COUNT);
    u_host.get(ipw_pkg::REG_ENABLE, q);
    chk8(q, ipw_pkg::ENABLE_ON);
    u_host.put(ipw_pkg::REG_BANK, 8'h00);                 // Another bank
    u_host.get(ipw_pkg::REG_ENABLE, q);
    chk8(q, 8'h00);
    u_host.put(ipw_pkg::REG_BANK, ipw_pkg::BANK_WDT);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_units();
    logic [7:0] md [3] = '{8'h10, 8'h18, 8'h00};  // Fast s, fast min, s
    int         un [3] = '{MSC, 60 * MSC, 1000 * MSC};
    int         uc [3] = '{3, 1, 1};
    int         n;
    logic [7:0] q;
    for (int i = 0; i < 3; i++) begin
      u_host.put(ipw_pkg::REG_UNIT, md[i]);
      u_host.get(ipw_pkg::REG_UNIT, q);
      chk8(q, md[i]);
      u_host.put(ipw_pkg::REG_COUNT, uc[i][7:0]);
      chk8(tmo, 8'h00);
      measure(uc[i] * un[i], n);
      chk_win(n, uc[i] * un[i]);
      chk8(cnt, 8'h00);
      u_host.get(ipw_pkg::REG_CTRL, q);
      chk8(q, 8'h10);
    end
    $display("t_units done");
  endtask : t_units
  task automatic t_reload();
    int n;
    u_host.put(ipw_pkg::REG_UNIT, 8'h10);
    u_host.put(ipw_pkg::REG_COUNT, 8'h05);
    repeat (30) @(negedge clk);
    u_host.put(ipw_pkg::REG_COUNT, 8'h05);
    ce = 1'b0;                                    // Frozen cycles must not count
    repeat (20) @(negedge clk);
    ce = 1'b1;
    measure(50, n);
    chk_win(n, 50);
    u_host.put(ipw_pkg::REG_COUNT, 8'h00);
    repeat (100) @(negedge clk);
    chk8({tmo, cnt}, 8'h00);
    $display("t_reload done");
  endtask : t_reload
  task automatic t_kbd();
    int         n;
    logic [7:0] q;
    u_host.put(ipw_pkg::REG_CTRL, 8'h40);
    u_host.put(ipw_pkg::REG_COUNT, 8'h04);
    repeat (3) begin
      repeat (30) @(negedge clk);
      kbd = 1'b1;
      @(negedge clk);
      kbd = 1'b0;
    end
    chk8(tmo, 8'h00);
    measure(40, n);
    chk_win(n, 40);
    u_host.get(ipw_pkg::REG_CTRL, q);
    chk8(q, 8'h50);
    $display("t_kbd done");
  endtask : t_kbd
  task automatic t_force();
    logic [7:0] q;
    u_host.put(ipw_pkg::REG_CTRL, 8'h00);
    u_host.put(ipw_pkg::REG_COUNT, 8'hC8);
    chk8(tmo, 8'h00);
    u_host.put(ipw_pkg::REG_CTRL, 8'h20);
    chk8(tmo, 8'h01);
    u_host.get(ipw_pkg::REG_CTRL, q);
    chk8(q, 8'h10);
    u_host.put(ipw_pkg::REG_COUNT, 8'h00);
    chk8({tmo, cnt}, 8'h00);
    $display("t_force done");
  endtask : t_force
  // ========================================================================
  // Verdict and run control
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_lock();
    t_units();
    t_reload();
    t_kbd();
    t_force();
    tally_and_finish();
  end
  // Hang guard, well beyond the expected run
  initial begin
    repeat (50000) @(negedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule : ipw_watchdog_tb_top
